// ==== shared/umc_pkg.sv ====
// package: modem control/status field layout, reset values and filter constants
package umc_pkg;
    // modem control register fields
    localparam int MCR_DTR_BIT = 0;
    localparam int MCR_RTS_BIT = 1;
    localparam int MCR_OUTA_BIT = 2;
    localparam int MCR_OUTB_BIT = 3;
    localparam int MCR_LOOP_BIT = 4;
    localparam logic [7:0] MCR_RESET = 8'h00;
    // modem status register fields
    localparam int MSR_DCTS_BIT = 0;
    localparam int MSR_DDSR_BIT = 1;
    localparam int MSR_RING_TRAILING_EDGE_FLAG_BIT = 2;
    localparam int MSR_DDCD_BIT = 3;
    localparam int MSR_CTS_BIT = 4;
    localparam int MSR_DSR_BIT = 5;
    localparam int MSR_RI_BIT = 6;
    localparam int MSR_DCD_BIT = 7;
    localparam logic [3:0] DELTA_RESET = 4'h0;
    // reset filter: stable cycles of the filter clock
    localparam int RST_FILTER_CYCLES = 8;
    localparam int RST_FILTER_W = 4;

    // active-low modem status inputs, pin level
    typedef struct packed {
        logic dcd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } umc_status_t;

    // active-low modem control outputs
    typedef struct packed {
        logic out_b_n;
        logic out_a_n;
        logic rts_n;
        logic dtr_n;
    } umc_control_t;
endpackage : umc_pkg

// ==== logic/umc_reset_filter.sv ====
// module: eight-cycle stability filter for the master reset input
`timescale 1ns/100ps
module umc_reset_filter #(
    parameter int CYCLES = umc_pkg::RST_FILTER_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic filt_en_i,
    input wire logic level_i,
    output logic qual_rst_n_o
);
    logic [umc_pkg::RST_FILTER_W-1:0] cnt_r;
    logic [umc_pkg::RST_FILTER_W-1:0] cnt_nxt;
    logic cand_r;
    logic cand_nxt;
    logic out_r;
    logic out_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        cand_nxt = cand_r;
        out_nxt = out_r;
        if (filt_en_i) begin
            if (level_i != cand_r) begin
                cand_nxt = level_i;
                cnt_nxt = umc_pkg::RST_FILTER_W'(1);
            end else if (cnt_r < umc_pkg::RST_FILTER_W'(CYCLES)) begin
                cnt_nxt = cnt_r + umc_pkg::RST_FILTER_W'(1);
            end
            if (level_i == cand_r && cnt_nxt >= umc_pkg::RST_FILTER_W'(CYCLES)) begin
                out_nxt = ~cand_r;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            cand_r <= 1'b0;
            out_r <= 1'b1;
        end else begin
            cnt_r <= cnt_nxt;
            cand_r <= cand_nxt;
            out_r <= out_nxt;
        end
    end

    assign qual_rst_n_o = out_r;
endmodule : umc_reset_filter

// ==== logic/umc_modem_ctrl.sv ====
// module: uart modem control and status logic with loop mode and reset qualifier
`timescale 1ns/100ps
module umc_modem_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic master_reset_i,
    input wire logic reset_filter_clock_i,
    input wire logic rclk_16x_i,
    input wire logic [7:0] mcr_wdata_i,
    input wire logic mcr_we_i,
    input wire logic msr_rd_i,
    input wire logic msi_en_i,
    input wire umc_pkg::umc_status_t status_n_i,
    input wire logic serial_input_i,
    output umc_pkg::umc_control_t control_n_o,
    output logic [7:0] modem_control_register_o,
    output logic [7:0] modem_status_register_o,
    output logic ring_trailing_edge_flag_o,
    output logic modem_status_irq_o,
    output logic rx_serial_o,
    output logic rx_clk_en_o,
    output logic qual_rst_n_o
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [6:0] sync1_r;
    logic [6:0] sync2_r;
    logic [6:0] sync1_nxt;
    logic [6:0] sync2_nxt;
    logic [2:0] edge_r;
    logic [2:0] edge_nxt;

    always_comb begin
        sync1_nxt = {rclk_16x_i, reset_filter_clock_i, master_reset_i, serial_input_i,
                     status_n_i.dcd_n, status_n_i.ri_n, status_n_i.dsr_n};
        sync2_nxt = sync1_r;
        edge_nxt = {sync2_r[6], sync2_r[5], 1'b0};
    end

    logic cts_sync1_r;
    logic cts_sync2_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_r <= 7'h7f;
            sync2_r <= 7'h7f;
            // match the synchroniser reset level so no false edge follows reset
            edge_r <= 3'h6;
            cts_sync1_r <= 1'b1;
            cts_sync2_r <= 1'b1;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            edge_r <= edge_nxt;
            cts_sync1_r <= status_n_i.cts_n;
            cts_sync2_r <= cts_sync1_r;
        end
    end

    logic dsr_pin_n;
    logic ri_pin_n;
    logic dcd_pin_n;
    logic sin_pin;
    logic mrst_sync;
    logic filt_en;

    assign dsr_pin_n = sync2_r[0];
    assign ri_pin_n = sync2_r[1];
    assign dcd_pin_n = sync2_r[2];
    assign sin_pin = sync2_r[3];
    assign mrst_sync = sync2_r[4];
    assign filt_en = sync2_r[5] & ~edge_r[1];
    // receiver clock enable on each rising edge of the 16x clock
    assign rx_clk_en_o = sync2_r[6] & ~edge_r[2];

    // ------------------------------------------------------------
    // reset qualification
    // ------------------------------------------------------------
    umc_reset_filter #(
        .CYCLES(umc_pkg::RST_FILTER_CYCLES)
    ) u_filter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .filt_en_i(filt_en),
        .level_i(mrst_sync),
        .qual_rst_n_o(qual_rst_n_o)
    );

    logic clr;
    assign clr = rst_i | mrst_sync;

    // ------------------------------------------------------------
    // modem control register
    // ------------------------------------------------------------
    logic [7:0] mcr_r;
    logic [7:0] mcr_nxt;
    logic loop_mode;

    always_comb begin
        mcr_nxt = mcr_r;
        if (mcr_we_i) begin
            mcr_nxt = {3'h0, mcr_wdata_i[4:0]};
        end
    end

    assign loop_mode = mcr_r[umc_pkg::MCR_LOOP_BIT];

    umc_pkg::umc_control_t ctl_r;
    umc_pkg::umc_control_t ctl_nxt;

    always_comb begin
        ctl_nxt.dtr_n = loop_mode | ~mcr_r[umc_pkg::MCR_DTR_BIT];
        ctl_nxt.rts_n = loop_mode | ~mcr_r[umc_pkg::MCR_RTS_BIT];
        ctl_nxt.out_a_n = loop_mode | ~mcr_r[umc_pkg::MCR_OUTA_BIT];
        ctl_nxt.out_b_n = loop_mode | ~mcr_r[umc_pkg::MCR_OUTB_BIT];
    end

    always_ff @(posedge clk_i) begin
        if (clr) begin
            mcr_r <= umc_pkg::MCR_RESET;
            ctl_r <= '1;
        end else begin
            mcr_r <= mcr_nxt;
            ctl_r <= ctl_nxt;
        end
    end

    assign control_n_o = ctl_r;
    assign modem_control_register_o = mcr_r;

    // ------------------------------------------------------------
    // serial input gating
    // ------------------------------------------------------------
    logic rx_r;
    logic rx_nxt;
    // loop feeds the transmitter marking level back, pin ignored
    assign rx_nxt = loop_mode ? 1'b1 : sin_pin;

    always_ff @(posedge clk_i) begin
        if (clr) begin
            rx_r <= 1'b1;
        end else begin
            rx_r <= rx_nxt;
        end
    end

    assign rx_serial_o = rx_r;

    // ------------------------------------------------------------
    // modem status register
    // ------------------------------------------------------------
    logic [3:0] lvl;
    logic [3:0] lvl_r;
    logic [3:0] lvl_nxt;
    logic [3:0] delta_r;
    logic [3:0] delta_nxt;
    logic [3:0] ev;
    logic irq_r;
    logic irq_nxt;

    // true-level status: {dcd, ri, dsr, cts}
    always_comb begin
        if (loop_mode) begin
            lvl = {mcr_r[umc_pkg::MCR_OUTB_BIT], mcr_r[umc_pkg::MCR_OUTA_BIT],
                   mcr_r[umc_pkg::MCR_DTR_BIT], mcr_r[umc_pkg::MCR_RTS_BIT]};
        end else begin
            lvl = ~{dcd_pin_n, ri_pin_n, dsr_pin_n, cts_sync2_r};
        end
    end

    always_comb begin
        lvl_nxt = lvl;
        ev[0] = lvl[0] ^ lvl_r[0];
        ev[1] = lvl[1] ^ lvl_r[1];
        // ring trailing edge: pin low to high, i.e. true level falls
        ev[2] = lvl_r[2] & ~lvl[2];
        ev[3] = lvl[3] ^ lvl_r[3];
        // set wins over read clear
        delta_nxt = (msr_rd_i ? 4'h0 : delta_r) | ev;
        irq_nxt = msi_en_i & (|ev);
    end

    always_ff @(posedge clk_i) begin
        if (clr) begin
            lvl_r <= 4'h0;
            delta_r <= umc_pkg::DELTA_RESET;
            irq_r <= 1'b0;
        end else begin
            lvl_r <= lvl_nxt;
            delta_r <= delta_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign modem_status_register_o = {lvl_r, delta_r};
    assign ring_trailing_edge_flag_o = delta_r[umc_pkg::MSR_RING_TRAILING_EDGE_FLAG_BIT];
    assign modem_status_irq_o = irq_r;
endmodule : umc_modem_ctrl

// ==== verif/umc_checker.sv ====
// checker: port-level properties of the modem control and status block
`timescale 1ns/100ps
module umc_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic master_reset_i,
    input wire logic msr_rd_i,
    input wire logic msi_en_i,
    input wire umc_pkg::umc_control_t control_n_o,
    input wire logic [7:0] modem_control_register_o,
    input wire logic [7:0] modem_status_register_o,
    input wire logic ring_trailing_edge_flag_o,
    input wire logic modem_status_irq_o,
    input wire logic rx_serial_o,
    input wire logic qual_rst_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic [7:0] mc = modem_control_register_o;
    wire logic [7:0] ms = modem_status_register_o;
    // outputs trail the register by one edge; a clear moves both at once
    property p_dtr; $stable(mc) |-> control_n_o.dtr_n == !(mc[0] && !mc[4]); endproperty
    a_dtr: assert property (p_dtr) else $error("dtr level wrong");
    property p_rts; $stable(mc) |-> control_n_o.rts_n == !(mc[1] && !mc[4]); endproperty
    a_rts: assert property (p_rts) else $error("rts level wrong");
    property p_outa; $stable(mc) |-> control_n_o.out_a_n == !(mc[2] && !mc[4]); endproperty
    a_outa: assert property (p_outa) else $error("user output a wrong");
    property p_outb; $stable(mc) |-> control_n_o.out_b_n == !(mc[3] && !mc[4]); endproperty
    a_outb: assert property (p_outb) else $error("user output b wrong");
    property p_rx; mc[4] |=> rx_serial_o; endproperty
    a_rx: assert property (p_rx) else $error("serial data passed in loop");
    property p_ring_trailing_edge_flag; $rose(ring_trailing_edge_flag_o) |-> $fell(ms[6]); endproperty
    a_ring_trailing_edge_flag: assert property (p_ring_trailing_edge_flag) else $error("ring flag without edge");
    property p_clr; msr_rd_i |=> !ring_trailing_edge_flag_o || $fell(ms[6]); endproperty
    a_clr: assert property (p_clr) else $error("ring flag kept after read");
    property p_dcd; $rose(ms[3]) |-> $changed(ms[7]); endproperty
    a_dcd: assert property (p_dcd) else $error("carrier delta without change");
    property p_irq; modem_status_irq_o |-> $past(msi_en_i) && (ms[3:0] != 4'h0); endproperty
    a_irq: assert property (p_irq) else $error("irq without enable or event");
    property p_qrst; $changed(qual_rst_n_o) |-> qual_rst_n_o == !master_reset_i; endproperty
    a_qrst: assert property (p_qrst) else $error("qualified reset wrong level");
    c_ring_trailing_edge_flag: cover property ($rose(ring_trailing_edge_flag_o));
    c_irq: cover property (modem_status_irq_o);
    c_qrst: cover property ($fell(qual_rst_n_o));
endmodule : umc_checker
bind umc_modem_ctrl umc_checker u_umc_checker (.clk_i, .rst_i, .master_reset_i, .msr_rd_i,
    .msi_en_i, .control_n_o, .modem_control_register_o, .modem_status_register_o,
    .ring_trailing_edge_flag_o, .modem_status_irq_o, .rx_serial_o, .qual_rst_n_o);

// ==== verif/umc_modem_model.sv ====
// model: modem side driving status pins, serial data and receive clock
`timescale 1ns/100ps
module umc_modem_model (
    input wire logic ring_i,
    input wire logic dcd_i,
    input wire logic send_i,
    input wire umc_pkg::umc_control_t control_n_i,
    output umc_pkg::umc_status_t status_n_o,
    output logic serial_o,
    output logic rclk_o
);
    initial rclk_o = 1'b0;
    initial serial_o = 1'b1;
    always #52 rclk_o = ~rclk_o;
    always @(posedge rclk_o) serial_o <= send_i ? ~serial_o : 1'b1;
    // data set answers terminal ready and request to send at once
    assign status_n_o = '{dcd_n: ~dcd_i, ri_n: ~ring_i, dsr_n: control_n_i.dtr_n,
                          cts_n: control_n_i.rts_n};
endmodule : umc_modem_model

// ==== verif/tb_top.sv ====
// testbench: control writes, status reads and reset filtering
`timescale 1ns/100ps
module tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1, mrst = 1'b0, fclk = 1'b0, we = 1'b0, rd = 1'b0;
    logic en = 1'b0, ring = 1'b0, dcd = 1'b0, send = 1'b0;
    logic [7:0] wd = 8'h00, modem_control_register, modem_status_register;
    logic flag, irq, rx, rxen, qrst, ser, rclk;
    logic [7:0] vals [8] = '{8'he1, 8'h02, 8'h04, 8'h08, 8'h0f, 8'h1f, 8'h15, 8'h00};
    umc_pkg::umc_control_t ctl;
    umc_pkg::umc_status_t sts;
    int n_fail = 0, num_checks = 0, n_irq = 0, n;
    always #4 clk_i = ~clk_i;
    always #20 fclk = ~fclk;
    always @(posedge clk_i) if (irq === 1'b1) n_irq <= n_irq + 1;
    umc_modem_ctrl u_umc_modem_ctrl (.clk_i(clk_i), .rst_i(rst_i), .master_reset_i(mrst),
        .reset_filter_clock_i(fclk), .rclk_16x_i(rclk), .mcr_wdata_i(wd), .mcr_we_i(we),
        .msr_rd_i(rd), .msi_en_i(en), .status_n_i(sts), .serial_input_i(ser),
        .control_n_o(ctl), .modem_control_register_o(modem_control_register), .modem_status_register_o(modem_status_register),
        .ring_trailing_edge_flag_o(flag), .modem_status_irq_o(irq), .rx_serial_o(rx),
        .rx_clk_en_o(rxen), .qual_rst_n_o(qrst));
    umc_modem_model u_umc_modem_model (.ring_i(ring), .dcd_i(dcd), .send_i(send),
        .control_n_i(ctl), .status_n_o(sts), .serial_o(ser), .rclk_o(rclk));
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(negedge clk_i);
    endtask : tick
    task automatic wr(input logic [7:0] d);
        we = 1'b1;
        wd = d;
        tick(1);
        we = 1'b0;
        tick(7);
    endtask : wr
    task automatic rd_msr;
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        tick(1);
    endtask : rd_msr
    task automatic conclude;
        if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    initial begin
        #50000;
        n_fail++;
        conclude;
    end
    initial begin
        tick(20);
        rst_i = 1'b0;
        tick(4);
        send = 1'b1;
        foreach (vals[i]) begin
            wr(vals[i]);
            chk(modem_control_register, {3'h0, vals[i][4:0]});
            chk({4'h0, ctl}, vals[i][4] ? 8'h0f : {4'h0, ~vals[i][3:0]});
            chk(modem_status_register & 8'hf0, {vals[i][4] & vals[i][3], vals[i][4] & vals[i][2], vals[i][0],
                vals[i][1], 4'h0});
            if (vals[i][4]) repeat (16) begin
                tick(1);
                chk({7'h0, rx}, 8'h01);
            end
        end
        for (int k = 0; k < 2; k++) begin
            en = (k == 0);
            ring = 1'b1;
            tick(5);
            rd_msr;
            chk(modem_status_register & 8'h44, 8'h40);
            n = n_irq;
            ring = 1'b0;
            tick(5);
            chk(modem_status_register & 8'h44, 8'h04);
            chk(8'(n_irq - n), {7'h0, k == 0});
            rd_msr;
            chk(modem_status_register & 8'h04, 8'h00);
        end
        dcd = 1'b1;
        tick(5);
        chk(modem_status_register & 8'h88, 8'h88);
        rd_msr;
        chk(modem_status_register & 8'h88, 8'h80);
        wr(8'h03);
        mrst = 1'b1;
        wr(8'h01);
        chk(modem_control_register, 8'h00);
        chk({7'h0, qrst}, 8'h01);
        tick(70);
        chk({7'h0, qrst}, 8'h00);
        mrst = 1'b0;
        tick(80);
        chk({7'h0, qrst}, 8'h01);
        conclude;
    end
endmodule : tb_top
